// ---- design/fsrc_area_enables.sv ----
`timescale 1ns/10ps
`include "fsrc_defines.svh"
module fsrc_area_enables
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// settings
	input  wire logic        sel_wr,
	input  wire logic [3:0]  sel_data,
	input  wire logic        en_wr,
	input  wire logic        en_data,
	input  wire logic        all_wr,
	input  wire logic        all_data,
	// state
	output logic      [3:0]  sel,
	output logic             sel_en,
	output logic             all_flag,
	output logic      [15:0] effective
);
	logic [15:0] en_bits;

	// area selector, low right after reset
	always_ff @(posedge clk)
	begin
		if (!nrst)
			sel <= `FSRC_AREA_SEL_RST;
		else if (sel_wr)
			sel <= sel_data;
	end

	// per-area enable bits
	always_ff @(posedge clk)
	begin
		if (!nrst)
			en_bits <= `FSRC_AREA_EN_RST;
		else if (en_wr)
			en_bits[sel] <= en_data;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			all_flag <= `FSRC_ALL_AREAS_RST;
		else if (all_wr)
			all_flag <= all_data;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			sel_en    <= 1'b0;
			effective <= 16'hFFFF;
		end
		else
		begin
			sel_en    <= en_bits[sel];
			effective <= all_flag ? 16'hFFFF : en_bits;
		end
	end
endmodule

// ---- design/fsrc_config.sv ----
`timescale 1ns/10ps
`include "fsrc_defines.svh"
// Operation
// - each table entry holds a region width limited to 96..1936, reset 1936.
// - each table entry holds a region height limited to 2..1216, reset 1216.
// - video send mode is plain, trigger stepped or command stepped, reset plain.
// - the entry selector takes 1..128, resets to 1 and picks the entry accessed.
// - in trigger mode each entry shows for its frame count then moves to its next index.
// - balance control speed is 1..8, reset 4.
module fsrc_config
	import fsrc_pkg::*;
#(
	parameter int ENTRIES = 128
)
(
	// clock and reset
	input  wire logic                 CLK_SYS,
	input  wire logic                 NRST,
	// mode and selector writes
	input  wire logic                 MODE_WR,
	input  wire logic [1:0]           MODE_DATA,
	input  wire logic                 INDEX_WR,
	input  wire fsrc_pkg::fsrc_index_t INDEX_DATA,
	// per-entry writes to the selected entry
	input  wire logic                 WIDTH_WR,
	input  wire fsrc_pkg::fsrc_dim_t  WIDTH_DATA,
	input  wire logic                 HEIGHT_WR,
	input  wire fsrc_pkg::fsrc_dim_t  HEIGHT_DATA,
	input  wire logic                 COUNT_WR,
	input  wire logic [7:0]           COUNT_DATA,
	input  wire logic                 NEXT_WR,
	input  wire fsrc_pkg::fsrc_index_t NEXT_DATA,
	// sequence control
	input  wire logic                 FRAME_START,
	input  wire logic                 RESET_SEQ,
	// balance settings
	input  wire logic                 SPEED_WR,
	input  wire logic [3:0]           SPEED_DATA,
	input  wire logic                 AREA_SEL_WR,
	input  wire logic [3:0]           AREA_SEL_DATA,
	input  wire logic                 AREA_EN_WR,
	input  wire logic                 AREA_EN_DATA,
	input  wire logic                 ALL_AREAS_WR,
	input  wire logic                 ALL_AREAS_DATA,
	// readback of selected entry and settings
	output fsrc_pkg::fsrc_mode_e      MODE,
	output fsrc_pkg::fsrc_index_t     INDEX,
	output fsrc_pkg::fsrc_dim_t       SEL_WIDTH,
	output fsrc_pkg::fsrc_dim_t       SEL_HEIGHT,
	output logic [7:0]                SEL_COUNT,
	output fsrc_pkg::fsrc_index_t     SEL_NEXT,
	output logic [3:0]                SPEED,
	output logic [3:0]                AREA_SEL,
	output logic                      AREA_SEL_EN,
	output logic                      ALL_AREAS,
	output logic [15:0]               AREA_MASK,
	// active region
	output fsrc_pkg::fsrc_index_t     CUR_INDEX,
	output fsrc_pkg::fsrc_dim_t       ROI_WIDTH,
	output fsrc_pkg::fsrc_dim_t       ROI_HEIGHT
);
	import fsrc_pkg::*;

	fsrc_dim_t   width_mem  [ENTRIES];
	fsrc_dim_t   height_mem [ENTRIES];
	logic [7:0]  count_mem  [ENTRIES];
	fsrc_index_t next_mem   [ENTRIES];
	fsrc_state_e state;
	logic [7:0]  frames;
	logic [6:0]  sel_slot;
	logic [6:0]  cur_slot;

	function automatic logic in_range(input logic [10:0] v, input logic [10:0] lo,
		input logic [10:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	function automatic logic [6:0] slot(input fsrc_index_t idx);
		slot = 7'(idx - 8'h01);
	endfunction

	assign sel_slot = slot(INDEX);
	assign cur_slot = slot(CUR_INDEX);

	// video send mode, out-of-list codes ignored
	always_ff @(posedge CLK_SYS)
	begin
		if (!NRST)
			MODE <= FSRC_PLAIN_VIDEO_OUTPUT;
		else if (MODE_WR && (MODE_DATA == 2'h0 || MODE_DATA == 2'h1 || MODE_DATA == 2'h3))
			MODE <= fsrc_mode_e'(MODE_DATA);
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!NRST)
			INDEX <= `FSRC_INDEX_RST;
		else if (INDEX_WR && in_range({3'h0, INDEX_DATA}, {3'h0, `FSRC_INDEX_MIN},
			{3'h0, `FSRC_INDEX_MAX}))
			INDEX <= INDEX_DATA;
	end

	// entry table, writes outside the range are ignored
	always_ff @(posedge CLK_SYS)
	begin
		if (!NRST)
		begin
			for (int i = 0; i < ENTRIES; i++)
			begin
				width_mem[i]  <= `FSRC_WIDTH_RST;
				height_mem[i] <= `FSRC_HEIGHT_RST;
				count_mem[i]  <= `FSRC_COUNT_RST;
				next_mem[i]   <= `FSRC_INDEX_RST;
			end
		end
		else
		begin
			if (WIDTH_WR && in_range(WIDTH_DATA, `FSRC_WIDTH_MIN, `FSRC_WIDTH_MAX))
				width_mem[sel_slot] <= WIDTH_DATA;
			if (HEIGHT_WR && in_range(HEIGHT_DATA, `FSRC_HEIGHT_MIN, `FSRC_HEIGHT_MAX))
				height_mem[sel_slot] <= HEIGHT_DATA;
			if (COUNT_WR && COUNT_DATA >= `FSRC_COUNT_MIN)
				count_mem[sel_slot] <= COUNT_DATA;
			if (NEXT_WR && in_range({3'h0, NEXT_DATA}, {3'h0, `FSRC_INDEX_MIN},
				{3'h0, `FSRC_INDEX_MAX}))
				next_mem[sel_slot] <= NEXT_DATA;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!NRST)
			SPEED <= `FSRC_SPEED_RST;
		else if (SPEED_WR && SPEED_DATA >= `FSRC_SPEED_MIN && SPEED_DATA <= `FSRC_SPEED_MAX)
			SPEED <= SPEED_DATA;
	end

	// sequencer: idle in plain mode, counts frames in trigger mode
	always_ff @(posedge CLK_SYS)
	begin
		if (!NRST || RESET_SEQ)
		begin
			state     <= FSRC_ST_IDLE;
			frames    <= 8'h00;
			CUR_INDEX <= `FSRC_INDEX_RST;
		end
		else
		begin
			case (state)
				FSRC_ST_IDLE:
				begin
					frames <= 8'h00;
					if (MODE == FSRC_TRIGGER_STEPPED_SEQ)
						state <= FSRC_ST_RUN;
					else if (MODE == FSRC_COMMAND_STEPPED_SEQ)
						CUR_INDEX <= INDEX;
				end
				FSRC_ST_RUN:
				begin
					if (MODE != FSRC_TRIGGER_STEPPED_SEQ)
						state <= FSRC_ST_IDLE;
					else if (FRAME_START)
					begin
						frames <= frames + 8'h01;
						if (frames + 8'h01 >= count_mem[cur_slot])
							state <= FSRC_ST_NEXT;
					end
				end
				FSRC_ST_NEXT:
				begin
					frames    <= 8'h00;
					CUR_INDEX <= next_mem[cur_slot];
					state     <= FSRC_ST_RUN;
				end
				default:
					state <= FSRC_ST_IDLE;
			endcase
		end
	end

	// readback and active region registers
	always_ff @(posedge CLK_SYS)
	begin
		if (!NRST)
		begin
			SEL_WIDTH  <= `FSRC_WIDTH_RST;
			SEL_HEIGHT <= `FSRC_HEIGHT_RST;
			SEL_COUNT  <= `FSRC_COUNT_RST;
			SEL_NEXT   <= `FSRC_INDEX_RST;
			ROI_WIDTH  <= `FSRC_WIDTH_RST;
			ROI_HEIGHT <= `FSRC_HEIGHT_RST;
		end
		else
		begin
			SEL_WIDTH  <= width_mem[sel_slot];
			SEL_HEIGHT <= height_mem[sel_slot];
			SEL_COUNT  <= count_mem[sel_slot];
			SEL_NEXT   <= next_mem[sel_slot];
			if (MODE == FSRC_PLAIN_VIDEO_OUTPUT)
			begin
				ROI_WIDTH  <= `FSRC_WIDTH_MAX;
				ROI_HEIGHT <= `FSRC_HEIGHT_MAX;
			end
			else
			begin
				ROI_WIDTH  <= width_mem[cur_slot];
				ROI_HEIGHT <= height_mem[cur_slot];
			end
		end
	end

	fsrc_area_enables u_areas
	(
		.clk       (CLK_SYS),
		.nrst      (NRST),
		.sel_wr    (AREA_SEL_WR),
		.sel_data  (AREA_SEL_DATA),
		.en_wr     (AREA_EN_WR),
		.en_data   (AREA_EN_DATA),
		.all_wr    (ALL_AREAS_WR),
		.all_data  (ALL_AREAS_DATA),
		.sel       (AREA_SEL),
		.sel_en    (AREA_SEL_EN),
		.all_flag  (ALL_AREAS),
		.effective (AREA_MASK)
	);
endmodule

// ---- design/fsrc_defines.svh ----
`ifndef FSRC_DEFINES_SVH
`define FSRC_DEFINES_SVH

`define FSRC_WIDTH_MIN      11'h060
`define FSRC_WIDTH_MAX      11'h790
`define FSRC_WIDTH_RST      11'h790
`define FSRC_HEIGHT_MIN     11'h002
`define FSRC_HEIGHT_MAX     11'h4C0
`define FSRC_HEIGHT_RST     11'h4C0
`define FSRC_COUNT_MIN      8'h01
`define FSRC_COUNT_MAX      8'hFF
`define FSRC_COUNT_RST      8'h01
`define FSRC_INDEX_MIN      8'h01
`define FSRC_INDEX_MAX      8'h80
`define FSRC_INDEX_RST      8'h01
`define FSRC_SPEED_MIN      4'h1
`define FSRC_SPEED_MAX      4'h8
`define FSRC_SPEED_RST      4'h4
`define FSRC_AREA_SEL_RST   4'h0
`define FSRC_AREA_EN_RST    16'h0000
`define FSRC_ALL_AREAS_RST  1'b1

`endif

// ---- design/fsrc_pkg.sv ----
package fsrc_pkg;
	typedef enum logic [1:0]
	{
		FSRC_PLAIN_VIDEO_OUTPUT      = 2'h0,
		FSRC_TRIGGER_STEPPED_SEQ     = 2'h1,
		FSRC_COMMAND_STEPPED_SEQ     = 2'h3
	} fsrc_mode_e;

	typedef enum logic [1:0]
	{
		FSRC_ST_IDLE = 2'h0,
		FSRC_ST_RUN  = 2'h1,
		FSRC_ST_NEXT = 2'h3
	} fsrc_state_e;

	typedef logic [7:0]  fsrc_index_t;
	typedef logic [10:0] fsrc_dim_t;
endpackage

// ---- tb/fsrc_config_properties.sv ----
`timescale 1ns/10ps
module fsrc_config_checker
	import fsrc_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic NRST,
	// writes and sequence control
	input wire logic MODE_WR,
	input wire logic [1:0] MODE_DATA,
	input wire logic INDEX_WR,
	input wire fsrc_pkg::fsrc_index_t INDEX_DATA,
	input wire logic SPEED_WR,
	input wire logic [3:0] SPEED_DATA,
	input wire logic FRAME_START,
	input wire logic RESET_SEQ,
	// state
	input wire fsrc_pkg::fsrc_mode_e MODE,
	input wire fsrc_pkg::fsrc_index_t INDEX,
	input wire logic [3:0] SPEED,
	input wire logic ALL_AREAS,
	input wire logic [15:0] AREA_MASK,
	input wire fsrc_pkg::fsrc_index_t CUR_INDEX
);
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);
	reset_values_a: assert property ($rose(NRST) |-> MODE == FSRC_PLAIN_VIDEO_OUTPUT
		&& INDEX == 8'h01 && SPEED == 4'h4 && ALL_AREAS) else $error("reset values");
	mode_write_a: assert property (MODE_WR && MODE_DATA != 2'h2 |=> MODE == $past(MODE_DATA))
		else $error("mode not taken");
	mode_refuse_a: assert property (MODE_WR && MODE_DATA == 2'h2 |=> $stable(MODE))
		else $error("mode code taken");
	index_keep_a: assert property (INDEX_WR && (INDEX_DATA == 8'h00 || INDEX_DATA > 8'h80)
		|=> $stable(INDEX)) else $error("bad index taken");
	speed_write_a: assert property (SPEED_WR |=> SPEED == ($past(SPEED_DATA) inside {[4'h1:4'h8]}
		? $past(SPEED_DATA) : $past(SPEED))) else $error("speed wrong");
	all_mask_a: assert property (ALL_AREAS |=> AREA_MASK == 16'hFFFF)
		else $error("mask not full");
	trig_hold_a: assert property (MODE == FSRC_TRIGGER_STEPPED_SEQ && $past(MODE) == MODE
		&& !FRAME_START && !$past(FRAME_START) && !RESET_SEQ |=> $stable(CUR_INDEX))
		else $error("index moved");
	seq_restart_a: assert property (MODE == FSRC_TRIGGER_STEPPED_SEQ && RESET_SEQ
		|=> CUR_INDEX == 8'h01) else $error("restart missed");
	cover property (MODE == FSRC_TRIGGER_STEPPED_SEQ && CUR_INDEX != $past(CUR_INDEX));
	cover property (INDEX_WR && INDEX_DATA > 8'h80);
	cover property (SPEED_WR && SPEED_DATA == 4'h9);
endmodule
bind fsrc_config fsrc_config_checker chk
(
	.CLK_SYS     (CLK_SYS),
	.NRST        (NRST),
	.MODE_WR     (MODE_WR),
	.MODE_DATA   (MODE_DATA),
	.INDEX_WR    (INDEX_WR),
	.INDEX_DATA  (INDEX_DATA),
	.SPEED_WR    (SPEED_WR),
	.SPEED_DATA  (SPEED_DATA),
	.FRAME_START (FRAME_START),
	.RESET_SEQ   (RESET_SEQ),
	.MODE        (MODE),
	.INDEX       (INDEX),
	.SPEED       (SPEED),
	.ALL_AREAS   (ALL_AREAS),
	.AREA_MASK   (AREA_MASK),
	.CUR_INDEX   (CUR_INDEX)
);

// ---- tb/fsrc_config_tb.sv ----
`timescale 1ns/10ps
module fsrc_config_tb;
	import fsrc_pkg::*;
	typedef struct {int k; logic [15:0] d; logic [15:0] e;} fsrc_row_s;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic run = 1'b0;
	logic [10:0] st = '0;
	logic [15:0] wd = '0;
	wire logic frame;
	int n_errors = 0;
	int n_compared = 0;
	logic [15:0] rst_exp[12] = '{0, 1, 4, 1936, 1216, 1, 1, 0, 0, 1, 1, 16'hFFFF};
	fsrc_row_s rows[] = '{'{0,1,1}, '{0,2,1}, '{0,3,3}, '{0,0,0}, '{2,8,8}, '{2,9,8}, '{2,0,8},
		'{1,128,128}, '{1,129,128}, '{1,0,128}, '{3,96,96}, '{3,95,96}, '{3,1937,96}, '{4,2,2},
		'{4,1,2}, '{4,1217,2}, '{5,255,255}, '{5,0,255}, '{6,129,1}, '{9,0,0}, '{7,5,5}, '{8,1,1},
		'{11,0,32}, '{9,1,1}, '{11,0,16'hFFFF}, '{1,1,1}, '{5,2,2}, '{6,3,3}, '{1,3,3},
		'{3,500,500}, '{0,1,1}};
	initial
	begin
		forever #20 clk = ~clk;
	end
	fsrc_config dut (.CLK_SYS(clk), .NRST(nrst), .MODE_WR(st[0]), .MODE_DATA(wd[1:0]),
		.INDEX_WR(st[1]), .INDEX_DATA(wd[7:0]), .SPEED_WR(st[2]), .SPEED_DATA(wd[3:0]),
		.WIDTH_WR(st[3]), .WIDTH_DATA(wd[10:0]), .HEIGHT_WR(st[4]), .HEIGHT_DATA(wd[10:0]),
		.COUNT_WR(st[5]), .COUNT_DATA(wd[7:0]), .NEXT_WR(st[6]), .NEXT_DATA(wd[7:0]),
		.AREA_SEL_WR(st[7]), .AREA_SEL_DATA(wd[3:0]), .AREA_EN_WR(st[8]), .AREA_EN_DATA(wd[0]),
		.ALL_AREAS_WR(st[9]), .ALL_AREAS_DATA(wd[0]), .RESET_SEQ(st[10]), .FRAME_START(frame),
		.MODE(), .INDEX(), .SEL_WIDTH(), .SEL_HEIGHT(), .SEL_COUNT(), .SEL_NEXT(), .SPEED(),
		.AREA_SEL(), .AREA_SEL_EN(), .ALL_AREAS(), .AREA_MASK(), .CUR_INDEX(), .ROI_WIDTH(),
		.ROI_HEIGHT());
	fsrc_frame_host host (.clk(clk), .nrst(nrst), .run(run), .frame(frame));
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [15:0] rd(input int k);
		case (k)
			0: rd = 16'(dut.MODE);
			1: rd = 16'(dut.INDEX);
			2: rd = 16'(dut.SPEED);
			3: rd = 16'(dut.SEL_WIDTH);
			4: rd = 16'(dut.SEL_HEIGHT);
			5: rd = 16'(dut.SEL_COUNT);
			6: rd = 16'(dut.SEL_NEXT);
			7: rd = 16'(dut.AREA_SEL);
			8: rd = 16'(dut.AREA_SEL_EN);
			9: rd = 16'(dut.ALL_AREAS);
			10: rd = 16'(dut.CUR_INDEX);
			default: rd = dut.AREA_MASK;
		endcase
	endfunction
	task automatic wr(input int k, input logic [15:0] d);
		st = 11'h001 << k;
		wd = d;
		@(posedge clk) #1;
		st = '0;
	endtask
	task automatic rst_chk();
		for (int k = 0; k < 12; k++)
			check("reset", rd(k), rst_exp[k]);
	endtask
	task automatic step(input logic [7:0] idx, input int frames, input logic [15:0] w);
		int n;
		int t;
		n = 0;
		for (t = 0; t < 60 && dut.CUR_INDEX !== idx; t++)
		begin
			n += int'(frame);
			@(posedge clk) #1;
		end
		if (t == 60)
		begin
			n_errors++;
			end_of_test();
		end
		check("frames", 16'(n), 16'(frames));
		@(posedge clk) #1;
		check("roi width", 16'(dut.ROI_WIDTH), w);
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		rst_chk();
		foreach (rows[i])
		begin
			wr(rows[i].k, rows[i].d);
			repeat (3) @(posedge clk);
			#1 check("row", rd(rows[i].k), rows[i].e);
		end
		wr(10, 0);
		run = 1'b1;
		step(3, 2, 500);
		step(1, 1, 1936);
		step(3, 2, 500);
		wr(10, 0);
		check("restart", rd(10), 1);
		run = 1'b0;
		wr(0, 3);
		@(posedge clk) #1;
		wr(1, 128);
		repeat (3) @(posedge clk);
		#1 check("command index", rd(10), 128);
		check("roi width", 16'(dut.ROI_WIDTH), 96);
		check("roi height", 16'(dut.ROI_HEIGHT), 2);
		wr(0, 0);
		repeat (3) @(posedge clk);
		#1 check("plain height", 16'(dut.ROI_HEIGHT), 1216);
		check("plain width", 16'(dut.ROI_WIDTH), 1936);
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		rst_chk();
		end_of_test();
	end
endmodule

// ---- tb/fsrc_frame_host.sv ----
`timescale 1ns/10ps
module fsrc_frame_host
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// control and frame pulse
	input wire logic run,
	output logic frame = 1'b0
);
	logic [1:0] phase = 2'h0;
	// one frame every fourth cycle
	always @(posedge clk)
	begin
		phase <= (nrst && run) ? phase + 2'h1 : 2'h0;
		frame <= nrst && run && phase == 2'h3;
	end
endmodule
